// ### link_host.sv
// Host model that drives the serial command link of the set-point block.
// Assumes the device samples on the rising link clock and shifts reads out.
`timescale 1ns/10ps
`default_nettype none
module link_host (
    // Link pins
    output logic      link_clk_o,
    output logic      link_sel_o,
    output logic      link_sdi_o,
    input  wire logic link_sdo_i
);
    initial begin
        link_clk_o = 1'b0;
        link_sel_o = 1'b0;
        link_sdi_o = 1'b0;
    end
    // The clock runs only inside frames, at a 64 ns period.
    task automatic put(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            link_sdi_o = b[i];
            #32 link_clk_o = 1'b1;
            #32 link_clk_o = 1'b0;
        end
    endtask : put
    task automatic wr(input logic [6:0] a, input logic [13:0] v, input bit word, bad);
        link_sel_o = 1'b1;
        #40;
        put(8'h30);
        put({~^a, a});
        put(word ? {~^v[6:0] ^ bad, v[6:0]} : v[7:0]);
        if (word)
            put({~^v[13:7], v[13:7]});
        link_sdi_o = ~link_sdi_o;
        #64 link_sel_o = 1'b0;
        #40;
    endtask : wr
    task automatic rd(output logic [15:0] d);
        link_sel_o = 1'b1;
        #40;
        put(8'h31);
        link_sdi_o = ~link_sdi_o;
        for (int i = 0; i < 16; i++) begin
            #32 d = {d[14:0], link_sdo_i};
            link_clk_o = 1'b1;
            #32 link_clk_o = 1'b0;
        end
        link_sel_o = 1'b0;
        #40;
    endtask : rd
endmodule : link_host
`default_nettype wire

// ### setpoint_pkg.sv
// Constants shared by the regulation set-point register block.
// Assumes a 125 MHz system clock and a byte-serial command link.
package setpoint_pkg;

    // Command addresses; the command byte carries odd parity in bit 7.
    localparam logic [6:0] OFF_VOM      = 7'h0e;
    localparam logic [6:0] OFF_CV       = 7'h10;
    localparam logic [6:0] OFF_LIVE     = 7'h14;
    localparam logic [6:0] OFF_LDC      = 7'h16;
    localparam logic [6:0] OFF_CC       = 7'h18;
    localparam logic [6:0] OFF_KNEE     = 7'h1a;
    localparam logic [7:0] PTR_CMD      = 8'h80;

    // Reset values.
    localparam logic [12:0] CV_RST      = 13'h01f4;
    localparam logic [7:0]  CC_RST      = 8'hc0;
    localparam logic [7:0]  KNEE_RST    = 8'hf0;
    localparam logic [3:0]  LDC_RST     = 4'h0;
    localparam logic [4:0]  VOM_RST     = 5'h04;
    localparam logic [7:0]  PTR_RST     = 8'h14;

    // Accepted code ranges.
    localparam logic [12:0] CV_MIN      = 13'h012c;
    localparam logic [12:0] CV_MAX      = 13'h0960;
    localparam logic [7:0]  CC_MIN      = 8'h1d;
    localparam logic [7:0]  CC_MAX      = 8'hc0;
    localparam logic [7:0]  KNEE_MIN    = 8'h35;
    localparam logic [7:0]  KNEE_MAX    = 8'hf0;
    localparam logic [3:0]  LDC_MAX     = 4'hc;

    // Field positions.
    localparam int VOM_EN_BIT           = 0;
    localparam int VOM_RESP_LSB         = 1;
    localparam int VOM_TMR_LSB          = 3;
    localparam int CV_AUTO_BIT          = 13;
    localparam int LIVE_READY_BIT       = 14;
    localparam int LIVE_AUTO_BIT        = 10;
    localparam int LIVE_BLEED_BIT       = 5;
    localparam int LIVE_MARGIN_BIT      = 4;

    // Peak overload response codes.
    localparam logic [1:0] RESP_DISC    = 2'h3;
    localparam logic [1:0] RESP_RETRY   = 2'h2;
    localparam logic [1:0] RESP_LATCH   = 2'h1;
    localparam logic [1:0] RESP_NONE    = 2'h0;

    // Regulation modes, one-hot.
    localparam logic [2:0] MODE_CV      = 3'h1;
    localparam logic [2:0] MODE_CP      = 3'h2;
    localparam logic [2:0] MODE_CC      = 3'h4;

    // Scaling: knee is 100 mV/LSB, voltage 10 mV/LSB, compensation 50 mV/LSB.
    localparam logic [11:0] KNEE_TO_CV  = 12'h00a;
    localparam logic [13:0] LDC_TO_CV   = 14'h0005;
    localparam logic [7:0]  FULL_SCALE  = 8'hc0;

    // Peak load timer base time.
    localparam int CLK_MHZ              = 125;
    localparam int PLT_BASE_MS          = 8;
    localparam int PLT_BASE_CYC         = PLT_BASE_MS * CLK_MHZ * 1000;

    typedef enum logic [2:0] {
        FS_IDLE   = 3'b001,
        FS_RX     = 3'b010,
        FS_COMMIT = 3'b100
    } frame_state_e;

endpackage : setpoint_pkg

// ### setpoint_regs.sv
// Set-point command registers with voltage-only mode supervision.
// Assumes a byte-serial link clocked by the host, frame select low between
// frames, and averaged current and voltage from same-clock logic.
//
// Functional notes
// - Ready flag high only when commands accepted.
// - Pointer 0x80 selects live word; bit 14.
// - Current limit uses averaged current measurement.
// - Voltage 3 V to 24 V, 10 mV, default 5 V.
// - Word data carries odd parity, checked first.
// - Current limit at 0x18, sent as 0x98.
// - Current limit codes 29 to 192.
// - Load rising: voltage, power, then current regulation.
// - Knee at 24 V removes power region.
// - Maximum power uses full-scale current, not limit.
// - Line drop code 0 to 12, 50 mV.
// - Line drop rises linearly to full-scale current.
// - Voltage-only mode: limit is overload threshold.
// - Overload starts peak timer, 8 to 64 ms.
// - Timer expiry applies selected overload response.
// - Defaults: self-retry response, 8 ms timer.
// - Disconnect opens switch, restores default configuration.
// - Auto thresholds 12.5 percent around set-point.
// - Downward auto step enables bleeder until margin clears.
// - Under-voltage protection forced in voltage-only mode.
`timescale 1ns/10ps
`default_nettype none

module setpoint_regs #(
    parameter int unsigned PLT_BASE_CYC       = setpoint_pkg::PLT_BASE_CYC,
    parameter logic [6:0]  TARGET_BUS_ADDRESS = 7'h18
) (
    // System clock and reset
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    // Serial command link
    input  wire logic        link_clk_i,
    input  wire logic        link_sel_i,
    input  wire logic        link_sdi_i,
    output logic             link_sdo_o,
    output logic             link_sdo_oe_o,
    // Measurements
    input  wire logic [7:0]  avg_current_i,
    input  wire logic [12:0] vout_meas_i,
    input  wire logic        margin_flag_i,
    // Regulation targets
    output logic [13:0]      vout_target_o,
    output logic [7:0]       current_limit_o,
    output logic [2:0]       reg_mode_o,
    output logic [13:0]      ov_thresh_o,
    output logic [13:0]      uv_thresh_o,
    output logic             auto_thr_en_o,
    output logic             uv_force_o,
    // Protection actions and status
    output logic             bleeder_en_o,
    output logic             bus_switch_open_o,
    output logic             self_retry_o,
    output logic             latch_shutdown_o,
    output logic             ready_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: shifts bytes in, shifts read data out.

    logic [2:0]  bit_cnt_l;
    logic [1:0]  byte_idx_l;
    logic [7:0]  shin_l;
    logic [7:0]  shin_nxt;
    logic [3:0]  valid_l;
    logic [7:0]  hold_l [4];
    logic [15:0] shout_l;
    logic        rd_frame_l;
    logic        sdo_oe_l;
    logic        byte_done;
    logic [15:0] rd_snap_r;

    assign shin_nxt  = {shin_l[6:0], link_sdi_i};
    assign byte_done = (bit_cnt_l == 3'h7) && !valid_l[3];

    // Frame select low clears the link state, so a stopped clock is harmless.
    always_ff @(posedge link_clk_i or negedge link_sel_i) begin
        if (!link_sel_i) begin
            bit_cnt_l  <= 3'h0;
            byte_idx_l <= 2'h0;
            shin_l     <= 8'h00;
            valid_l    <= 4'h0;
            shout_l    <= 16'h0000;
            rd_frame_l <= 1'b0;
            sdo_oe_l   <= 1'b0;
        end else begin
            shin_l    <= shin_nxt;
            bit_cnt_l <= bit_cnt_l + 3'h1;
            if (byte_done) begin
                valid_l[byte_idx_l] <= 1'b1;
                if (byte_idx_l != 2'h3) begin
                    byte_idx_l <= byte_idx_l + 2'h1;
                end
            end
            if (byte_done && byte_idx_l == 2'h0 && shin_nxt == {TARGET_BUS_ADDRESS, 1'b1}) begin
                rd_frame_l <= 1'b1;
                sdo_oe_l   <= 1'b1;
                shout_l    <= rd_snap_r;
            end else if (rd_frame_l) begin
                shout_l <= {shout_l[14:0], 1'b0};
            end
        end
    end

    // Byte holds stay stable until the main domain has seen the valid level.
    always_ff @(posedge link_clk_i) begin
        if (byte_done) begin
            hold_l[byte_idx_l] <= shin_nxt;
        end
    end

    assign link_sdo_o    = shout_l[15];
    assign link_sdo_oe_o = sdo_oe_l;

    ////////////////////////////////////////////////////////////////////////////
    // Crossings into the system clock domain.

    logic       sel_s1, sel_s2, sel_d;
    logic [3:0] vld_s1, vld_s2, vld_d;
    logic       mg_s1, mg_s2, mg_d;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
            sel_d  <= 1'b0;
            vld_s1 <= 4'h0;
            vld_s2 <= 4'h0;
            vld_d  <= 4'h0;
            mg_s1  <= 1'b0;
            mg_s2  <= 1'b0;
            mg_d   <= 1'b0;
        end else begin
            sel_s1 <= link_sel_i;
            sel_s2 <= sel_s1;
            sel_d  <= sel_s2;
            vld_s1 <= valid_l;
            vld_s2 <= vld_s1;
            vld_d  <= vld_s2;
            mg_s1  <= margin_flag_i;
            mg_s2  <= mg_s1;
            mg_d   <= mg_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame reception and commit.

    setpoint_pkg::frame_state_e fstate_r;
    logic [7:0]  rx_r [4];
    logic [3:0]  got_r;
    logic [15:0] live_word;
    logic        ready_r;
    logic        auto_thr_r;
    logic        bleed_r;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            fstate_r  <= setpoint_pkg::FS_IDLE;
            got_r     <= 4'h0;
            rd_snap_r <= 16'h0000;
        end else begin
            case (fstate_r)
                setpoint_pkg::FS_IDLE: begin
                    if (sel_s2 && !sel_d) begin
                        fstate_r  <= setpoint_pkg::FS_RX;
                        got_r     <= 4'h0;
                        rd_snap_r <= live_word;
                    end
                end
                setpoint_pkg::FS_RX: begin
                    for (int i = 0; i < 4; i++) begin
                        if (vld_s2[i] && !vld_d[i]) begin
                            rx_r[i]  <= hold_l[i];
                            got_r[i] <= 1'b1;
                        end
                    end
                    if (!sel_s2) begin
                        fstate_r <= setpoint_pkg::FS_COMMIT;
                    end
                end
                setpoint_pkg::FS_COMMIT: begin
                    fstate_r <= setpoint_pkg::FS_IDLE;
                end
                default: begin
                    fstate_r <= setpoint_pkg::FS_IDLE;
                end
            endcase
        end
    end

    logic        commit, addr_ok, cmd_ok, word_ok, byte_ok;
    logic [7:0]  cmd_b, lo_b, hi_b;
    logic [13:0] word;

    // low byte first, parity in bit 7
    assign cmd_b   = rx_r[1];
    assign lo_b    = rx_r[2];
    assign hi_b    = rx_r[3];
    assign word    = {hi_b[6:0], lo_b[6:0]};
    assign commit  = (fstate_r == setpoint_pkg::FS_COMMIT);
    assign addr_ok = got_r[0] && rx_r[0] == {TARGET_BUS_ADDRESS, 1'b0};
    // odd parity on command and both data bytes
    assign cmd_ok  = commit && addr_ok && got_r[1] && ^cmd_b;
    assign word_ok = cmd_ok && got_r[2] && got_r[3] && ^lo_b && ^hi_b;
    assign byte_ok = cmd_ok && got_r[2];

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers.

    logic [12:0] cv_r;
    logic [7:0]  cc_r;
    logic [7:0]  knee_r;
    logic [3:0]  ldc_r;
    logic [4:0]  vom_r;
    logic [7:0]  ptr_r;
    logic        disc_r;
    logic        plt_fire;
    logic        vom_en;
    logic [1:0]  vom_resp;
    logic [1:0]  vom_tmr;
    logic        to_default;

    assign vom_en     = vom_r[setpoint_pkg::VOM_EN_BIT];
    assign vom_resp   = vom_r[setpoint_pkg::VOM_RESP_LSB +: 2];
    assign vom_tmr    = vom_r[setpoint_pkg::VOM_TMR_LSB +: 2];
    assign to_default = plt_fire && vom_resp == setpoint_pkg::RESP_DISC;

    always_ff @(posedge mclk_i) begin
        if (reset_i || to_default) begin
            cv_r   <= setpoint_pkg::CV_RST;
            cc_r   <= setpoint_pkg::CC_RST;
            knee_r <= setpoint_pkg::KNEE_RST;
            ldc_r  <= setpoint_pkg::LDC_RST;
            vom_r  <= setpoint_pkg::VOM_RST;
            ptr_r  <= setpoint_pkg::PTR_RST;
        end else begin
            if (byte_ok && cmd_b[6:0] == setpoint_pkg::OFF_VOM) begin
                vom_r <= lo_b[4:0];
            end
            if (word_ok && cmd_b[6:0] == setpoint_pkg::OFF_CV
                    && word[12:0] >= setpoint_pkg::CV_MIN
                    && word[12:0] <= setpoint_pkg::CV_MAX) begin
                cv_r <= word[12:0];
            end
            // current limit accepted only in range
            if (word_ok && cmd_b[6:0] == setpoint_pkg::OFF_CC && word[13:8] == 6'h00
                    && word[7:0] >= setpoint_pkg::CC_MIN
                    && word[7:0] <= setpoint_pkg::CC_MAX) begin
                cc_r <= word[7:0];
            end
            if (word_ok && cmd_b[6:0] == setpoint_pkg::OFF_KNEE && word[13:8] == 6'h00
                    && word[7:0] >= setpoint_pkg::KNEE_MIN
                    && word[7:0] <= setpoint_pkg::KNEE_MAX) begin
                knee_r <= word[7:0];
            end
            if (byte_ok && cmd_b[6:0] == setpoint_pkg::OFF_LDC && lo_b[7:4] == 4'h0
                    && lo_b[3:0] <= setpoint_pkg::LDC_MAX) begin
                ldc_r <= lo_b[3:0];
            end
            if (byte_ok && cmd_b == setpoint_pkg::PTR_CMD) begin
                ptr_r <= lo_b;
            end
        end
    end

    logic cv_write;
    logic cv_down;
    assign cv_write = word_ok && cmd_b[6:0] == setpoint_pkg::OFF_CV
                      && word[12:0] >= setpoint_pkg::CV_MIN
                      && word[12:0] <= setpoint_pkg::CV_MAX;
    assign cv_down  = word[12:0] < cv_r;

    // auto thresholds follow a flagged write in voltage-only mode
    always_ff @(posedge mclk_i) begin
        if (reset_i || to_default) begin
            auto_thr_r <= 1'b0;
        end else if (cv_write) begin
            auto_thr_r <= vom_en && word[setpoint_pkg::CV_AUTO_BIT];
        end
    end

    // bleeder on downward auto step, off when margin flag clears
    always_ff @(posedge mclk_i) begin
        if (reset_i || to_default) begin
            bleed_r <= 1'b0;
        end else if (cv_write && vom_en && word[setpoint_pkg::CV_AUTO_BIT] && cv_down) begin
            bleed_r <= 1'b1;
        end else if (mg_d && !mg_s2) begin
            bleed_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Peak load timer and overload response.

    logic [23:0] plt_cnt_r;
    logic [23:0] plt_lim;
    logic        overload;
    logic        retry_r;
    logic        latch_r;

    // timer length 8, 16, 32 or 64 ms
    assign plt_lim  = 24'(PLT_BASE_CYC) << vom_tmr;
    // limit acts as overload threshold on averaged current
    assign overload = vom_en && avg_current_i > cc_r;
    assign plt_fire = overload && plt_cnt_r == plt_lim - 24'h1;

    always_ff @(posedge mclk_i) begin
        if (reset_i || !overload || plt_fire) begin
            plt_cnt_r <= 24'h0;
        end else begin
            plt_cnt_r <= plt_cnt_r + 24'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            retry_r <= 1'b0;
            latch_r <= 1'b0;
            disc_r  <= 1'b0;
        end else begin
            retry_r <= plt_fire && vom_resp == setpoint_pkg::RESP_RETRY;
            if (plt_fire && vom_resp == setpoint_pkg::RESP_LATCH) begin
                latch_r <= 1'b1;
            end
            if (to_default) begin
                disc_r <= 1'b1;
            end
        end
    end

    // ready only when commands can take effect
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ready_r <= 1'b0;
        end else begin
            ready_r <= !latch_r && !plt_fire && !retry_r;
        end
    end

    always_comb begin
        live_word = 16'h0000;
        if (ptr_r[6:0] == setpoint_pkg::OFF_LIVE) begin
            live_word[setpoint_pkg::LIVE_READY_BIT]  = ready_r;
            live_word[setpoint_pkg::LIVE_AUTO_BIT]   = auto_thr_r;
            live_word[setpoint_pkg::LIVE_BLEED_BIT]  = bleed_r;
            live_word[setpoint_pkg::LIVE_MARGIN_BIT] = mg_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Regulation targets.

    logic [11:0] knee_cv;
    logic [20:0] pwr_now, pwr_max;
    logic        cp_active;
    logic [2:0]  mode_nxt;
    logic [7:0]  avg_clip;
    logic [13:0] comp_num;
    logic [5:0]  comp;

    assign knee_cv   = 12'({4'h0, knee_r} * setpoint_pkg::KNEE_TO_CV);
    assign pwr_now   = 21'(avg_current_i) * 21'(vout_meas_i);
    // power limit from knee and full-scale current only
    assign pwr_max   = 21'(knee_cv) * 21'(setpoint_pkg::FULL_SCALE);
    // knee at maximum disables the power region
    assign cp_active = knee_r != setpoint_pkg::KNEE_MAX
                       && 13'(knee_cv) <= vout_meas_i && pwr_now >= pwr_max;

    // voltage, then power, then current regulation
    always_comb begin
        if (vom_en) begin
            mode_nxt = setpoint_pkg::MODE_CV;
        end else if (cp_active) begin
            mode_nxt = setpoint_pkg::MODE_CP;
        end else if (avg_current_i >= cc_r) begin
            mode_nxt = setpoint_pkg::MODE_CC;
        end else begin
            mode_nxt = setpoint_pkg::MODE_CV;
        end
    end

    // compensation linear in current up to full scale
    assign avg_clip = (avg_current_i > setpoint_pkg::FULL_SCALE) ? setpoint_pkg::FULL_SCALE
                                                                 : avg_current_i;
    assign comp_num = 14'({10'h000, ldc_r} * setpoint_pkg::LDC_TO_CV) * 14'(avg_clip);
    assign comp     = 6'(comp_num / 14'(setpoint_pkg::FULL_SCALE));

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            reg_mode_o    <= setpoint_pkg::MODE_CV;
            vout_target_o <= 14'(setpoint_pkg::CV_RST);
            ov_thresh_o   <= 14'h0000;
            uv_thresh_o   <= 14'h0000;
        end else begin
            reg_mode_o    <= mode_nxt;
            vout_target_o <= 14'(cv_r) + 14'(comp);
            ov_thresh_o   <= 14'(cv_r) + 14'(cv_r[12:3]);
            uv_thresh_o   <= 14'(cv_r) - 14'(cv_r[12:3]);
        end
    end

    // under-voltage protection forced on in voltage-only mode
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            current_limit_o   <= setpoint_pkg::CC_RST;
            auto_thr_en_o     <= 1'b0;
            uv_force_o        <= 1'b0;
            bleeder_en_o      <= 1'b0;
            bus_switch_open_o <= 1'b0;
            self_retry_o      <= 1'b0;
            latch_shutdown_o  <= 1'b0;
            ready_o           <= 1'b0;
        end else begin
            current_limit_o   <= cc_r;
            auto_thr_en_o     <= auto_thr_r;
            uv_force_o        <= vom_en;
            bleeder_en_o      <= bleed_r;
            bus_switch_open_o <= disc_r;
            self_retry_o      <= retry_r;
            latch_shutdown_o  <= latch_r;
            ready_o           <= ready_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    sequence s_retry_pulse;
        retry_r ##1 self_retry_o ##1 !self_retry_o;
    endsequence

    a_ready_latched: assert property (latch_r |=> !ready_r ##1 !ready_o)
        else $error("ready shown while latched");
    a_cv_bounds: assert property (cv_r >= setpoint_pkg::CV_MIN && cv_r <= setpoint_pkg::CV_MAX)
        else $error("voltage set-point out of range");
    a_cc_bounds: assert property (cc_r >= setpoint_pkg::CC_MIN && cc_r <= setpoint_pkg::CC_MAX)
        else $error("current limit out of range");
    a_ldc_bounds: assert property (ldc_r <= setpoint_pkg::LDC_MAX)
        else $error("line drop code out of range");
    a_parity_reject: assert property (commit && !word_ok && !to_default |=> $stable(cc_r) && $stable(cv_r))
        else $error("word taken without parity");
    a_timer_idle: assert property (!vom_en |=> plt_cnt_r == 24'h0)
        else $error("peak timer runs outside voltage-only mode");
    a_timer_length: assert property (plt_fire |-> plt_cnt_r == plt_lim - 24'h1 && overload)
        else $error("peak timer fired at wrong count");
    a_retry_resp: assert property (plt_fire && vom_resp == setpoint_pkg::RESP_RETRY |=> s_retry_pulse)
        else $error("self-retry pulse wrong");
    a_disc_default: assert property (to_default |=> cv_r == setpoint_pkg::CV_RST && vom_r == setpoint_pkg::VOM_RST ##1 bus_switch_open_o)
        else $error("disconnect did not restore defaults");
    a_knee_nopower: assert property (knee_r == setpoint_pkg::KNEE_MAX |=> reg_mode_o != setpoint_pkg::MODE_CP)
        else $error("power region with knee at maximum");
    a_bleed_off: assert property (bleed_r && mg_d && !mg_s2 && !cv_write |=> !bleed_r ##1 !bleeder_en_o)
        else $error("bleeder stays on after margin clear");
    a_uv_force: assert property (vom_en |=> uv_force_o)
        else $error("under-voltage not forced");

endmodule : setpoint_regs

`default_nettype wire

// ### setpoint_regs_bench.sv
// Self-checking bench for the set-point register block.
// Assumes the host model in link_host.sv and a 50-cycle peak timer base.
`timescale 1ns/10ps
`default_nettype none
module setpoint_regs_bench;
    logic mclk_i = 1'b0, reset_i = 1'b1, lclk, lsel, lsdi, sdo, oe, mflag = 1'b0;
    logic [7:0] cur = 8'h00, lim;
    logic [13:0] vt, ov, uv;
    logic [12:0] vm = 13'h01f4;
    logic [2:0] md;
    logic aen, uvf, bl, bso, sr, ls, rdy;
    logic [15:0] d;
    int n_errors = 0;
    int tests_run = 0;
    initial forever #4 mclk_i = ~mclk_i;
    link_host link_host_i (.link_clk_o(lclk), .link_sel_o(lsel), .link_sdi_o(lsdi),
        .link_sdo_i(sdo));
    setpoint_regs #(.PLT_BASE_CYC(50)) setpoint_regs_i (.mclk_i(mclk_i), .reset_i(reset_i),
        .link_clk_i(lclk), .link_sel_i(lsel), .link_sdi_i(lsdi), .link_sdo_o(sdo),
        .link_sdo_oe_o(oe), .avg_current_i(cur), .vout_meas_i(vm),
        .margin_flag_i(mflag), .vout_target_o(vt), .current_limit_o(lim),
        .reg_mode_o(md), .ov_thresh_o(ov), .uv_thresh_o(uv), .auto_thr_en_o(aen),
        .uv_force_o(uvf), .bleeder_en_o(bl), .bus_switch_open_o(bso),
        .self_retry_o(sr), .latch_shutdown_o(ls), .ready_o(rdy));
    task automatic chk(input logic [15:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : cyc
    task automatic w(input logic [6:0] a, input logic [13:0] v, input bit word, bad);
        link_host_i.wr(a, v, word, bad);
        cyc(10);
    endtask : w
    task automatic t_reset;
        chk(vt, 14'd500);
        chk({uvf, aen, bso}, 3'b000);
        w(7'h00, 14'h0014, 1'b0, 1'b0);
        link_host_i.rd(d);
        chk(d, 16'h4000);
        chk(oe, 1'b0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_limit;
        w(7'h18, 14'h0060, 1'b1, 1'b0);
        chk(lim, 8'h60);
        w(7'h18, 14'h0020, 1'b1, 1'b1);
        chk(lim, 8'h60);
        w(7'h18, 14'd29, 1'b1, 1'b0);
        chk(lim, 8'd29);
        w(7'h18, 14'd28, 1'b1, 1'b0);
        w(7'h18, 14'd193, 1'b1, 1'b0);
        chk(lim, 8'd29);
        w(7'h10, 14'd299, 1'b1, 1'b0);
        chk(vt, 14'd500);
        w(7'h10, 14'd300, 1'b1, 1'b0);
        chk(vt, 14'd300);
        cur = 8'h40;
        cyc(2);
        chk(md, 3'h4);
        w(7'h1a, 14'h0050, 1'b1, 1'b0);
        vm = 13'd1000;
        cyc(2);
        chk(md, 3'h4);
        cur = 8'hc0;
        cyc(2);
        chk(md, 3'h2);
        w(7'h16, 14'h0006, 1'b0, 1'b0);
        chk(vt, 14'd330);
        w(7'h16, 14'h000d, 1'b0, 1'b0);
        chk(vt, 14'd330);
        w(7'h1a, 14'h00f0, 1'b1, 1'b0);
        chk(md, 3'h4);
        cur = 8'h00;
        cyc(2);
        chk(md, 3'h1);
        $display("test limits done");
    endtask : t_limit
    task automatic t_peak(input logic [7:0] mode, input bit disc);
        int n;
        n = 0;
        w(7'h0e, {6'h00, mode}, 1'b0, 1'b0);
        chk(uvf, 1'b1);
        w(7'h10, 14'h2320, 1'b1, 1'b0);
        chk(aen, 1'b1);
        chk(ov, 14'd900);
        chk(uv, 14'd700);
        // down step with auto flag, bleeder on until margin clears
        w(7'h10, 14'h2258, 1'b1, 1'b0);
        chk(bl, 1'b1);
        mflag = 1'b1;
        cyc(6);
        mflag = 1'b0;
        cyc(6);
        chk(bl, 1'b0);
        cur = 8'h40;
        while (n < 300 && !(disc ? bso === 1'b1 : sr === 1'b1)) begin
            cyc(1);
            n++;
        end
        if (disc)
            chk({bso, lim, uvf}, {1'b1, 8'hc0, 1'b0});
        else
            chk(n >= 50 && n <= 58, 1'b1);
        cur = 8'h00;
        cyc(5);
        $display("test peak mode %h done", mode);
    endtask : t_peak
    task automatic t_latch;
        int n;
        n = 0;
        w(7'h0e, 14'h000b, 1'b0, 1'b0);
        cur = 8'hff;
        while (n < 300 && ls !== 1'b1) begin
            cyc(1);
            n++;
        end
        chk(n >= 100 && n <= 108, 1'b1);
        cyc(2);
        chk(rdy, 1'b0);
        cur = 8'h00;
        link_host_i.rd(d);
        chk(d, 16'h0000);
        reset_i = 1'b1;
        cyc(3);
        reset_i = 1'b0;
        cyc(6);
        chk({ls, rdy, uvf}, 3'b010);
        $display("test latch done");
    endtask : t_latch
    task automatic wrap_up;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        #300000;
        n_errors++;
        wrap_up();
    end
    initial begin
        cyc(20);
        reset_i = 1'b0;
        cyc(6);
        t_reset();
        t_limit();
        t_peak(8'h05, 1'b0);
        t_peak(8'h07, 1'b1);
        t_latch();
        wrap_up();
    end
endmodule : setpoint_regs_bench
`default_nettype wire
